/* File: ulc_pkg.sv */
package ulc_pkg;

  // register port
  localparam int unsigned REG_ADDR_W  = 12;
  localparam logic [11:0] CFG0_OFFSET = 12'h080;
  localparam logic [11:0] STAT_OFFSET = 12'h084;

  // configuration word field positions
  localparam int unsigned RSV_POS   = 31;
  localparam int unsigned LPM_POS   = 30;
  localparam int unsigned SUSP_POS  = 29;
  localparam int unsigned THR_LSB   = 24;
  localparam int unsigned THR_W     = 5;
  localparam int unsigned IN_LSB    = 20;
  localparam int unsigned OUT_LSB   = 16;
  localparam int unsigned BURST_W   = 4;
  localparam int unsigned SPEED_LSB = 13;
  localparam int unsigned SPEED_W   = 3;
  localparam int unsigned OVL_POS   = 12;

  // status word field positions
  localparam int unsigned STAT_DEEP_POS  = 0;
  localparam int unsigned STAT_SLEEP_POS = 1;
  localparam int unsigned STAT_SUSPN_POS = 2;
  localparam int unsigned STAT_WAIT_POS  = 3;
  localparam int unsigned STAT_SPOK_POS  = 4;

  // connect speed codes
  localparam logic [2:0] SPEED_SS = 3'h4;
  localparam logic [2:0] SPEED_HS = 3'h0;
  localparam logic [2:0] SPEED_FS = 3'h1;

  // resume threshold signalling time, microseconds
  localparam logic [10:0] THR_BASE_US = 11'h032;
  localparam logic [10:0] THR_STEP_US = 11'h04B;

  // reset values
  localparam logic       RST_LPM   = 1'b0;
  localparam logic       RST_SUSP  = 1'b0;
  localparam logic [4:0] RST_THR   = 5'h00;
  localparam logic [3:0] RST_IN    = 4'h0;
  localparam logic [3:0] RST_OUT   = 4'h0;
  localparam logic [2:0] RST_SPEED = SPEED_SS;
  localparam logic       RST_OVL   = 1'b0;

  typedef enum logic [0:0] {
    EXIT_IDLE,
    EXIT_WAIT
  } ulc_exit_e;

  typedef struct packed {
    logic       power_mgmt_capability_en;
    logic       suspend_allow;
    logic [4:0] l1_resume_duration_threshold;
    logic [3:0] in_endpoint_burst_limit;
    logic [3:0] out_endpoint_burst_limit;
    logic [2:0] connect_speed_select;
    logic       exit_overlap_check_en;
  } ulc_cfg_s;

  typedef struct packed {
    logic       suspend_cond;
    logic       partner_lfps;
    logic       l1_active;
    logic [3:0] host_resume_duration_value;
    logic       ux_exit_start;
    logic       partner_ts;
  } ulc_link_in_s;

  typedef struct packed {
    logic suspend_n;
    logic deep_low_power;
    logic utmi_sleep;
  } ulc_phy_s;

  typedef struct packed {
    logic        lfps_handshake_done;
    logic        speed_ss;
    logic        speed_hs;
    logic        speed_fs;
    logic        speed_valid;
    logic [4:0]  in_packets;
    logic [4:0]  out_packets;
    logic [10:0] thr_time_us;
  } ulc_link_out_s;

  typedef struct packed {
    ulc_cfg_s      cfg;
    ulc_phy_s      phy;
    ulc_link_out_s lnk;
    ulc_exit_e     exit_st;
    logic [31:0]   rdata;
  } ulc_state_s;

  localparam ulc_cfg_s CFG_RST = '{RST_LPM, RST_SUSP, RST_THR, RST_IN, RST_OUT, RST_SPEED, RST_OVL};
  localparam ulc_phy_s PHY_RST = '{1'b1, 1'b0, 1'b0};
  localparam ulc_link_out_s LNK_RST = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h01, 5'h01, THR_BASE_US};
  localparam ulc_state_s ST_RST = '{CFG_RST, PHY_RST, LNK_RST, EXIT_IDLE, 32'h00000000};

endpackage

/* File: ulc_sync2.sv */
`timescale 1ns/1ps
module ulc_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ulc_sync_s;

  ulc_sync_s st_reg;
  ulc_sync_s st_next;

  // stage1 feeds only stage2
  always_comb begin
    st_next.stage1 = async_i;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.stage2;

endmodule

/* File: ulc_usb_link_cfg.sv */
`timescale 1ns/1ps
// Behaviour
// - link power management capability output follows config bit 30.
// - suspend indicator stays deasserted while suspend_allow is zero.
// - in L1, deep low-power when resume value >= threshold[3:0] and threshold[4] set.
// - in L1, UTMI sleep when resume value below threshold or threshold[4] clear.
// - threshold time is 50 us plus 75 us per step of threshold[3:0]; threshold[4] does not add to it.
// - bulk-in burst limit in bits 23:20, packets minus one.
// - bulk-out burst limit in bits 19:16, packets minus one.
// - speed field 15:13: 100 super, 000 high, 001 full; resets to 100.
// - with overlap check on, U-state exit waits for partner LFPS or TS symbols.
// - with overlap check off, U-state exit completes without LFPS overlap.
module ulc_usb_link_cfg
  import ulc_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // link and phy side
  input  wire ulc_link_in_s          link_i,
  output ulc_cfg_s                   cfg_o,
  output ulc_phy_s                   phy_o,
  output ulc_link_out_s              link_o
);

  ulc_state_s st_reg;
  ulc_state_s st_next;
  logic [1:0] pin_sync;
  logic       susp_cond_s;
  logic       lfps_s;
  logic       deep_ok;
  logic [4:0] thr;
  logic       wr_cfg;

  function automatic logic [31:0] cfg_to_word(input ulc_cfg_s c);
    logic [31:0] w;
    w                               = 32'h00000000;
    w[LPM_POS]                      = c.power_mgmt_capability_en;
    w[SUSP_POS]                     = c.suspend_allow;
    w[THR_LSB +: THR_W]             = c.l1_resume_duration_threshold;
    w[IN_LSB +: BURST_W]            = c.in_endpoint_burst_limit;
    w[OUT_LSB +: BURST_W]           = c.out_endpoint_burst_limit;
    w[SPEED_LSB +: SPEED_W]         = c.connect_speed_select;
    w[OVL_POS]                      = c.exit_overlap_check_en;
    w[RSV_POS]                      = 1'b0;
    return w;
  endfunction

  function automatic ulc_cfg_s word_to_cfg(input logic [31:0] w);
    ulc_cfg_s c;
    c.power_mgmt_capability_en     = w[LPM_POS];
    c.suspend_allow                = w[SUSP_POS];
    c.l1_resume_duration_threshold = w[THR_LSB +: THR_W];
    c.in_endpoint_burst_limit      = w[IN_LSB +: BURST_W];
    c.out_endpoint_burst_limit     = w[OUT_LSB +: BURST_W];
    c.connect_speed_select         = w[SPEED_LSB +: SPEED_W];
    c.exit_overlap_check_en        = w[OVL_POS];
    return c;
  endfunction

  function automatic logic deep_allowed(input logic [4:0] t, input logic [3:0] resume_val);
    return t[4] & (resume_val >= t[3:0]);
  endfunction

  // suspend condition and partner lfps come from the analog front end
  ulc_sync2 #(
    .WIDTH (2)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({link_i.partner_lfps, link_i.suspend_cond}),
    .sync_o    (pin_sync)
  );

  assign susp_cond_s = pin_sync[0];
  assign lfps_s      = pin_sync[1];
  assign thr         = st_reg.cfg.l1_resume_duration_threshold;
  assign wr_cfg      = reg_wr_i && (reg_addr_i == CFG0_OFFSET);

  always_comb begin
    st_next                         = st_reg;
    st_next.rdata                   = 32'h00000000;
    st_next.lnk.lfps_handshake_done = 1'b0;
    deep_ok                         = deep_allowed(thr, link_i.host_resume_duration_value);

    // register writes; bit 31 and bits 11:0 are dropped
    if (wr_cfg) begin
      st_next.cfg = word_to_cfg(reg_wdata_i);
    end

    // read data stands only in the cycle after the strobe
    if (reg_rd_i) begin
      if (reg_addr_i == CFG0_OFFSET) begin
        st_next.rdata = cfg_to_word(st_reg.cfg);
      end else if (reg_addr_i == STAT_OFFSET) begin
        st_next.rdata[STAT_DEEP_POS]  = st_reg.phy.deep_low_power;
        st_next.rdata[STAT_SLEEP_POS] = st_reg.phy.utmi_sleep;
        st_next.rdata[STAT_SUSPN_POS] = st_reg.phy.suspend_n;
        st_next.rdata[STAT_WAIT_POS]  = (st_reg.exit_st == EXIT_WAIT);
        st_next.rdata[STAT_SPOK_POS]  = st_reg.lnk.speed_valid;
      end
    end

    // suspend indicator is active low
    st_next.phy.suspend_n      = ~(st_reg.cfg.suspend_allow & susp_cond_s);
    st_next.phy.deep_low_power = link_i.l1_active & deep_ok;
    st_next.phy.utmi_sleep     = link_i.l1_active & ~deep_ok;

    // derived link settings
    st_next.lnk.thr_time_us = THR_BASE_US + THR_STEP_US * {7'h00, thr[3:0]};
    st_next.lnk.in_packets  = {1'b0, st_reg.cfg.in_endpoint_burst_limit} + 5'h01;
    st_next.lnk.out_packets = {1'b0, st_reg.cfg.out_endpoint_burst_limit} + 5'h01;
    st_next.lnk.speed_ss    = (st_reg.cfg.connect_speed_select == SPEED_SS);
    st_next.lnk.speed_hs    = (st_reg.cfg.connect_speed_select == SPEED_HS);
    st_next.lnk.speed_fs    = (st_reg.cfg.connect_speed_select == SPEED_FS);
    st_next.lnk.speed_valid = st_next.lnk.speed_ss | st_next.lnk.speed_hs | st_next.lnk.speed_fs;

    // low-power exit handshake
    unique case (st_reg.exit_st)
      EXIT_IDLE: begin
        if (link_i.ux_exit_start) begin
          if (st_reg.cfg.exit_overlap_check_en) begin
            st_next.exit_st = EXIT_WAIT;
          end else begin
            st_next.lnk.lfps_handshake_done = 1'b1;
          end
        end
      end
      EXIT_WAIT: begin
        if (lfps_s || link_i.partner_ts) begin
          st_next.lnk.lfps_handshake_done = 1'b1;
          st_next.exit_st                 = EXIT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign cfg_o       = st_reg.cfg;
  assign phy_o       = st_reg.phy;
  assign link_o      = st_reg.lnk;

  // capability bit lands on the output one edge after the write
  AST_LPM_FOLLOWS_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_cfg |=> (cfg_o.power_mgmt_capability_en == $past(reg_wdata_i[LPM_POS]))
  ) else $error("capability bit does not follow the write");

  AST_LPM_HOLDS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !wr_cfg |=> $stable(cfg_o.power_mgmt_capability_en)
  ) else $error("capability bit changed without a write");

  AST_SUSPEND_BLOCKED: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !st_reg.cfg.suspend_allow |=> phy_o.suspend_n
  ) else $error("suspend asserted while not allowed");

  AST_SUSPEND_ENTERS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg.cfg.suspend_allow && susp_cond_s) |=> !phy_o.suspend_n
  ) else $error("suspend not entered although allowed");

  AST_DEEP_ENTRY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (link_i.l1_active && thr[4] && (link_i.host_resume_duration_value >= thr[3:0]))
      |=> (phy_o.deep_low_power && !phy_o.utmi_sleep)
  ) else $error("deep low-power not chosen in L1");

  AST_SLEEP_ENTRY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (link_i.l1_active && (!thr[4] || (link_i.host_resume_duration_value < thr[3:0])))
      |=> (phy_o.utmi_sleep && !phy_o.deep_low_power)
  ) else $error("utmi sleep not chosen in L1");

  AST_NO_LOW_POWER_OUTSIDE_L1: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !link_i.l1_active |=> !(phy_o.utmi_sleep || phy_o.deep_low_power)
  ) else $error("low-power mode outside L1");

  AST_THR_TIME: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (link_o.thr_time_us == (11'd50 + 11'd75 * {7'h00, $past(thr[3:0])}))
  ) else $error("threshold time is not 50 us plus 75 us per step");

  AST_IN_PACKETS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_cfg |=> ##1 (link_o.in_packets == {1'b0, $past(reg_wdata_i[23:20], 2)} + 5'h01)
  ) else $error("bulk-in packet count wrong");

  AST_OUT_PACKETS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_cfg |=> ##1 (link_o.out_packets == {1'b0, $past(reg_wdata_i[19:16], 2)} + 5'h01)
  ) else $error("bulk-out packet count wrong");

  AST_SPEED_RESET: assert property (
    @(posedge sys_clk_i)
    !rst_n_i |=> (cfg_o.connect_speed_select == 3'b100) && link_o.speed_ss
  ) else $error("speed field does not reset to super speed");

  AST_SPEED_DECODE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 ((link_o.speed_hs == ($past(cfg_o.connect_speed_select) == 3'b000))
      && (link_o.speed_fs == ($past(cfg_o.connect_speed_select) == 3'b001)))
  ) else $error("speed decode wrong");

  AST_OVERLAP_WAIT: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg.exit_st == EXIT_WAIT && !lfps_s && !link_i.partner_ts)
      |=> (!link_o.lfps_handshake_done && st_reg.exit_st == EXIT_WAIT)
  ) else $error("handshake completed without partner lfps or ts");

  AST_OVERLAP_SEEN: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg.exit_st == EXIT_WAIT && (lfps_s || link_i.partner_ts))
      |=> (link_o.lfps_handshake_done && st_reg.exit_st == EXIT_IDLE)
  ) else $error("handshake not completed after partner symbols");

  AST_NO_OVERLAP: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg.exit_st == EXIT_IDLE && link_i.ux_exit_start && !st_reg.cfg.exit_overlap_check_en)
      |=> (link_o.lfps_handshake_done ##1 (!link_o.lfps_handshake_done || $past(link_i.ux_exit_start)))
  ) else $error("exit without overlap check did not complete at once");

  AST_RESERVED_ZERO: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i && reg_addr_i == CFG0_OFFSET)
      |-> (reg_rdata_o[31] == 1'b0 && reg_rdata_o[11:0] == 12'h000)
  ) else $error("reserved bits read nonzero");

  AST_READ_ONE_CYCLE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> (reg_rdata_o == 32'h00000000)
  ) else $error("read data outside its cycle");

  AST_DONE_HAS_CAUSE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    link_o.lfps_handshake_done
      |-> $past((st_reg.exit_st == EXIT_WAIT && (lfps_s || link_i.partner_ts))
      || (st_reg.exit_st == EXIT_IDLE && link_i.ux_exit_start && !st_reg.cfg.exit_overlap_check_en))
  ) else $error("handshake done without a cause");

  AST_WAIT_ENTRY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg.exit_st == EXIT_IDLE && link_i.ux_exit_start && st_reg.cfg.exit_overlap_check_en)
      |=> (st_reg.exit_st == EXIT_WAIT && !link_o.lfps_handshake_done)
  ) else $error("exit with overlap check did not wait");

  AST_NO_WAIT_WITHOUT_CHECK: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_reg.exit_st == EXIT_IDLE && link_i.ux_exit_start && !st_reg.cfg.exit_overlap_check_en)
      |=> (st_reg.exit_st == EXIT_IDLE)
  ) else $error("exit without overlap check entered the wait");

  AST_DONE_ONE_CYCLE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (link_o.lfps_handshake_done && !link_i.ux_exit_start) |=> !link_o.lfps_handshake_done
  ) else $error("handshake done longer than one cycle");

  AST_CFG_FOLLOWS_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_cfg |=> (cfg_o == $past(reg_wdata_i[30:12]))
  ) else $error("config fields do not follow the write");

  AST_CFG_HOLDS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !wr_cfg |=> $stable(cfg_o)
  ) else $error("config fields changed without a write");

  AST_CFG_RESET: assert property (
    @(posedge sys_clk_i)
    !rst_n_i |=> (cfg_o == CFG_RST)
  ) else $error("config fields not at reset value");

  AST_PHY_RESET: assert property (
    @(posedge sys_clk_i)
    !rst_n_i |=> (phy_o.suspend_n && !phy_o.deep_low_power && !phy_o.utmi_sleep)
  ) else $error("phy controls not idle after reset");

  AST_IN_PACKETS_LEVEL: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (link_o.in_packets == {1'b0, $past(cfg_o.in_endpoint_burst_limit)} + 5'h01)
  ) else $error("bulk-in packet count does not track the field");

  AST_OUT_PACKETS_LEVEL: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (link_o.out_packets == {1'b0, $past(cfg_o.out_endpoint_burst_limit)} + 5'h01)
  ) else $error("bulk-out packet count does not track the field");

  AST_THR_AFTER_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_cfg |=> ##1 (link_o.thr_time_us == 11'h032 + 11'h04B * {7'h00, $past(reg_wdata_i[27:24], 2)})
  ) else $error("threshold time wrong after a write");

  AST_SPEED_SS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (link_o.speed_ss == ($past(cfg_o.connect_speed_select) == 3'b100))
  ) else $error("super speed decode wrong");

  AST_SPEED_VALID: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ##1 (link_o.speed_valid == ($past(cfg_o.connect_speed_select) inside {3'b100, 3'b000, 3'b001}))
  ) else $error("speed valid flag wrong");

  AST_SPEED_ONEHOT: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $onehot0({link_o.speed_ss, link_o.speed_hs, link_o.speed_fs})
  ) else $error("more than one speed selected");

  AST_DEEP_SLEEP_EXCL: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !(phy_o.deep_low_power && phy_o.utmi_sleep)
  ) else $error("deep low-power and sleep at once");

  AST_SUSPEND_IDLE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !susp_cond_s |=> phy_o.suspend_n
  ) else $error("suspend asserted without suspend conditions");

  AST_SUSPEND_WRITE_OFF: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_cfg && !reg_wdata_i[SUSP_POS]) |=> ##1 phy_o.suspend_n
  ) else $error("suspend asserted after it was disallowed");

  AST_STAT_PHY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i && reg_addr_i == STAT_OFFSET)
      |-> (reg_rdata_o[2:0] == $past({phy_o.suspend_n, phy_o.utmi_sleep, phy_o.deep_low_power}))
  ) else $error("status does not mirror the phy controls");

  AST_STAT_UPPER: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i && reg_addr_i == STAT_OFFSET) |-> (reg_rdata_o[31:5] == 27'h0000000)
  ) else $error("unused status bits read nonzero");

  AST_UNMAPPED_READ: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i && reg_addr_i != CFG0_OFFSET && reg_addr_i != STAT_OFFSET)
      |-> (reg_rdata_o == 32'h00000000)
  ) else $error("unmapped read returned data");

endmodule

/* File: ulc_host_model.sv */
`timescale 1ns/1ps
module ulc_host_model
  import ulc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // bench controls
  input  wire logic       l1_i,
  input  wire logic [3:0] resume_i,
  input  wire logic       susp_i,
  input  wire logic       exit_i,
  input  wire logic       lfps_i,
  input  wire logic [3:0] delay_i,
  // link toward the device
  output ulc_link_in_s    link_o
);
  logic [3:0] cnt_reg;
  logic [2:0] hold_reg;
  logic       ans;

  // answer the exit after delay_i cycles, hold it five cycles, then let it drop
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= 4'h0;
      hold_reg <= 3'h0;
    end else begin
      if (exit_i) begin
        cnt_reg <= delay_i;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
      if (cnt_reg == 4'h1) begin
        hold_reg <= 3'h5;
      end else if (hold_reg != 3'h0) begin
        hold_reg <= hold_reg - 3'h1;
      end
    end
  end

  assign ans = (hold_reg != 3'h0);
  assign link_o = '{susp_i, lfps_i & ans, l1_i, resume_i, exit_i, ~lfps_i & ans};
endmodule

/* File: usb_link_config_power_ctrl_test.sv */
`timescale 1ns/1ps
module usb_link_config_power_ctrl_test;
  import ulc_pkg::*;
  logic                  sys_clk_i;
  logic                  rst_n_i;
  logic [REG_ADDR_W-1:0] reg_addr_i;
  logic [31:0]           reg_wdata_i;
  logic                  reg_wr_i;
  logic                  reg_rd_i;
  logic [31:0]           reg_rdata_o;
  ulc_link_in_s          link_i;
  ulc_cfg_s              cfg_o;
  ulc_phy_s              phy_o;
  ulc_link_out_s         link_o;
  logic                  l1;
  logic                  susp;
  logic                  ext;
  logic                  lfps;
  logic [3:0]            resume;
  logic [3:0]            dly;
  logic [31:0]           seed;
  logic [31:0]           w;
  logic [31:0]           rd_val;
  logic [2:0]            s;
  logic                  e;
  int                    err_count;
  int                    checks_done;
  int                    n;

  ulc_usb_link_cfg ulc_usb_link_cfg_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .link_i(link_i), .cfg_o(cfg_o), .phy_o(phy_o), .link_o(link_o));
  ulc_host_model ulc_host_model_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .l1_i(l1), .resume_i(resume),
    .susp_i(susp), .exit_i(ext), .lfps_i(lfps), .delay_i(dly), .link_o(link_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    tally_and_finish();
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    seed = 32'h0000005A;
    rst_n_i <= 1'b0;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    reg_addr_i <= 12'h000;
    reg_wdata_i <= 32'h00000000;
    {l1, susp, ext, lfps, resume, dly} <= 12'h000;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(CFG0_OFFSET);
    chk("cfg0 reset", 32'h00008000, rd_val);
    chk("suspend_n reset", 32'h1, phy_o.suspend_n);
    wr(STAT_OFFSET, 32'hFFFFFFFF);
    wr(12'h100, 32'hFFFFFFFF);
    rd(CFG0_OFFSET);
    chk("cfg0 after stray writes", 32'h00008000, rd_val);
    rd(12'h100);
    chk("unmapped read", 32'h00000000, rd_val);
    // random configurations, every speed code twice
    for (int i = 0; i < 16; i++) begin
      w = xs();
      w = w & 32'hFF33FFFF;
      w[15:13] = 3'(i);
      s = w[15:13];
      resume <= 4'(xs());
      l1 <= (i % 4 != 3);
      wr(CFG0_OFFSET, w);
      tick(2);
      e = l1 & w[28] & (resume >= w[27:24]);
      chk("cfg fields", 32'(w[30:12]), 32'(cfg_o));
      chk("capability", 32'(w[30]), 32'(cfg_o.power_mgmt_capability_en));
      chk("deep and sleep", {30'h0, e, l1 & ~e}, {30'h0, phy_o.deep_low_power, phy_o.utmi_sleep});
      chk("threshold time", 32'(50 + 75 * w[27:24]), 32'(link_o.thr_time_us));
      chk("in packets", 32'(w[23:20]) + 32'h1, 32'(link_o.in_packets));
      chk("out packets", 32'(w[19:16]) + 32'h1, 32'(link_o.out_packets));
      chk("speed decode", {28'h0, s == 3'h4, s == 3'h0, s == 3'h1, s == 3'h4 || s <= 3'h1},
        {28'h0, link_o.speed_ss, link_o.speed_hs, link_o.speed_fs, link_o.speed_valid});
      rd(CFG0_OFFSET);
      chk("cfg0 readback", w & 32'h7FFFF000, rd_val);
      rd(STAT_OFFSET);
      chk("status", {27'h0, s == 3'h4 || s <= 3'h1, 1'b0, 1'b1, l1 & ~e, e}, rd_val);
    end
    l1 <= 1'b0;
    susp <= 1'b1;
    wr(CFG0_OFFSET, 32'h00008000);
    tick(6);
    chk("suspend blocked", 32'h1, 32'(phy_o.suspend_n));
    wr(CFG0_OFFSET, 32'h20008000);
    tick(5);
    chk("suspend entered", 32'h0, 32'(phy_o.suspend_n));
    susp <= 1'b0;
    tick(5);
    chk("suspend left", 32'h1, 32'(phy_o.suspend_n));
    // exits with the overlap check off and on, answered by TS or LFPS
    for (int j = 0; j < 8; j++) begin
      w = 32'h00008000;
      w[12] = j[0];
      lfps <= j[1];
      dly <= 4'h1 + 4'(xs() % 6);
      wr(CFG0_OFFSET, w);
      tick(2);
      @(posedge sys_clk_i);
      ext <= 1'b1;
      @(posedge sys_clk_i);
      ext <= 1'b0;
      #1;
      n = 1;
      while (link_o.lfps_handshake_done !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      chk("exit latency", w[12] ? 32'(dly) + 32'h2 + (lfps ? 32'h2 : 32'h0) : 32'h1, n);
      tick(12);
    end
    // second reset in mid-run brings every field back
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(CFG0_OFFSET);
    chk("cfg0 after second reset", 32'h00008000, rd_val);
    chk("packets after second reset", 32'h00000021, {22'h0, link_o.in_packets, link_o.out_packets});
    tally_and_finish();
  end
endmodule
